/* design/instr_timing_decoder.sv */
// instruction fetch sequencing, cycle timing and operand decode for the core
`timescale 1ns/10ps
module instr_timing_decoder import decode_pkg::*; #(
   parameter int FLOW_EXTRA_CYCLES = 1,
   parameter int READ_EXTRA_CYCLES = 1
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic fetch_valid_in,
   input wire logic [INSTR_W-1:0] fetch_word_in,
   input wire logic fetch_two_word_in,
   input wire operand_class_t operand_class_in,
   input wire logic cond_true_in,
   input wire logic flow_change_in,
   input wire logic program_space_visibility_read_in,
   input wire logic table_read_in,
   input wire logic special_function_register_read_in,
   input wire logic skip_taken_in,
   input wire logic reg_write_in,
   input wire logic flag_update_in,
   input wire logic sticky_zero_mode_in,
   input wire mcu_flags_t mcu_flags_in,
   input wire dsp_flags_t dsp_flags_in,
   output logic fetch_ready_out,
   output logic exec_valid_out,
   output logic nop_slot_out,
   output logic retire_out,
   output logic [1:0] retire_cycles_out,
   output decoded_t decoded_out,
   output prefetch_t x_prefetch_out,
   output prefetch_t y_prefetch_out,
   output logic operand_error_out,
   output logic second_word_error_out,
   output logic reg_write_out,
   output mcu_flags_t mcu_flags_out,
   output dsp_flags_t dsp_flags_out
);

   // ---------------------------------------------------------------
   // reset synchroniser
   // ---------------------------------------------------------------
   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ---------------------------------------------------------------
   // operand decode helpers
   // ---------------------------------------------------------------
   // prefetch address modes
   function automatic prefetch_t decode_prefetch(input logic [3:0] code,
                                                 input logic [3:0] first_reg,
                                                 input logic [1:0] dest_code);
      prefetch_t p;
      p = '0;
      p.enable = 1'b1;
      p.pointer = first_reg + {3'h0, code[3]};
      p.dest = REG_W4 + {2'h0, dest_code};
      case (code[2:0])
         3'h0: p.step = 3'h0;
         3'h1: p.step = PF_STEP2;
         3'h2: p.step = PF_STEP4;
         3'h3: p.step = PF_STEP6;
         3'h4: begin
            // only the second pointer has an indexed form; the first slot means none
            if (code[3]) begin
               p.indexed = 1'b1;
            end else begin
               p = '0;
            end
         end
         3'h5: begin
            p.decrement = 1'b1;
            p.step = PF_STEP2;
         end
         3'h6: begin
            p.decrement = 1'b1;
            p.step = PF_STEP4;
         end
         default: begin
            p.decrement = 1'b1;
            p.step = PF_STEP6;
         end
      endcase
      return p;
   endfunction

   function automatic logic [7:0] mul_pair(input logic [2:0] code);
      logic [7:0] r;
      case (code)
         3'h0: r = {REG_W4, REG_W4 + 4'h1};
         3'h1: r = {REG_W4, REG_W4 + 4'h2};
         3'h2: r = {REG_W4, REG_W4 + 4'h3};
         3'h3: r = {REG_W4 + 4'h1, REG_W4 + 4'h2};
         3'h4: r = {REG_W4 + 4'h1, REG_W4 + 4'h3};
         default: r = {REG_W4 + 4'h2, REG_W4 + 4'h3};
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // combinational decode of the fetched word
   // ---------------------------------------------------------------
   logic [15:0] op;
   logic [7:0] opc;
   decoded_t word_dec;
   logic word_error;
   logic [1:0] awb_code;
   logic [2:0] pair_code;
   logic [7:0] pair_regs;

   assign opc = fetch_word_in[INSTR_W-1:OPC_LSB];
   assign op = fetch_word_in[OPERAND_W-1:0];
   assign awb_code = fetch_word_in[F_AWB_LSB +: 2];
   assign pair_code = op[F_PAIR_LSB +: 3];
   assign pair_regs = mul_pair(pair_code);

   always_comb begin
      word_dec = '0;
      word_dec.opcode = opc;
      word_dec.operand = op;
      word_dec.base_working_reg = op[F_BASE_LSB +: 4];
      word_dec.source_working_reg = op[F_SRC_LSB +: 4];
      word_dec.dest_working_reg = op[F_DST_LSB +: 4];
      word_dec.default_file_working_reg = REG_W0;
      word_dec.file_dest_is_default_file_working_reg = op[F_DEFAULT_FILE_WORKING_REG_BIT];
      word_dec.file_addr = op[12:0] & FILE_ADDR_MAX;
      word_dec.bit_position_field = op[F_BITPOS_LSB +: 4];
      word_dec.ten_bit_literal = op[F_TEN_BIT_LITERAL_LSB +: 10];
      word_dec.byte_mode = op[F_BYTE_BIT];
      word_dec.acc_b_select = op[F_ACC_BIT];
      word_dec.accumulator_writeback_target = awb_code;
      if (operand_class_in == CLS_SQUARE) begin
         word_dec.multiplicand_reg = REG_W4 + {2'h0, op[F_PAIR_LSB +: 2]};
         word_dec.multiplier_reg = REG_W4 + {2'h0, op[F_PAIR_LSB +: 2]};
      end else begin
         word_dec.multiplicand_reg = pair_regs[7:4];
         word_dec.multiplier_reg = pair_regs[3:0];
      end
   end

   always_comb begin
      word_error = 1'b0;
      case (operand_class_in)
         CLS_LIT: word_error = op[F_BYTE_BIT] && (op[F_TEN_BIT_LITERAL_LSB +: 10] > TEN_BIT_LITERAL_BYTE_MAX);
         CLS_MUL: word_error = (pair_code > MUL_PAIR_LAST) ||
                               (awb_code > AWB_POSTINC);
         CLS_SQUARE: word_error = (awb_code > AWB_POSTINC);
         default: word_error = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   state_t state;
   state_t next_state;
   logic [7:0] stall_cnt;
   logic [7:0] next_stall_cnt;
   logic skip_second;
   logic next_skip_second;
   logic [1:0] cycles;
   logic [1:0] next_cycles;
   logic accept;
   logic slot;
   logic next_nop;
   logic next_exec;
   logic next_retire;
   logic [7:0] extra;
   logic flow_extra;
   logic read_extra;

   assign accept = fetch_valid_in && fetch_ready_out;
   assign flow_extra = cond_true_in || flow_change_in;
   assign read_extra = program_space_visibility_read_in || table_read_in ||
                       special_function_register_read_in;

   always_comb begin
      extra = 8'h00;
      if (flow_extra && (FLOW_EXTRA_CYCLES > 0)) begin
         extra = 8'(FLOW_EXTRA_CYCLES);
      end
      if (read_extra && (8'(READ_EXTRA_CYCLES) > extra)) begin
         extra = 8'(READ_EXTRA_CYCLES);
      end
   end

   always_comb begin
      next_state = state;
      next_stall_cnt = stall_cnt;
      next_skip_second = skip_second;
      next_nop = 1'b0;
      next_exec = 1'b0;
      next_retire = 1'b0;
      slot = 1'b0;
      case (state)
         ST_RUN: begin
            if (accept) begin
               slot = 1'b1;
               if (fetch_two_word_in) begin
                  // second cycle takes the extension word
                  next_state = ST_SECOND;
               end else if (opc == SECOND_WORD_OPC) begin
                  next_nop = 1'b1;
                  next_retire = 1'b1;
               end else if (skip_taken_in) begin
                  next_exec = 1'b1;
                  next_state = ST_SKIP;
               end else if (extra != 8'h00) begin
                  next_exec = 1'b1;
                  next_state = ST_STALL;
                  next_stall_cnt = extra;
               end else begin
                  next_exec = 1'b1;
                  next_retire = 1'b1;
               end
            end
         end
         ST_SECOND: begin
            if (accept) begin
               slot = 1'b1;
               next_exec = 1'b1;
               next_retire = 1'b1;
               next_state = ST_RUN;
            end
         end
         ST_SKIP: begin
            if (accept) begin
               slot = 1'b1;
               next_nop = 1'b1;
               if (fetch_two_word_in && !skip_second) begin
                  next_skip_second = 1'b1;
               end else begin
                  next_skip_second = 1'b0;
                  next_retire = 1'b1;
                  next_state = ST_RUN;
               end
            end
         end
         ST_STALL: begin
            slot = 1'b1;
            next_nop = 1'b1;
            next_stall_cnt = stall_cnt - 8'h01;
            if (stall_cnt == 8'h01) begin
               next_retire = 1'b1;
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_comb begin
      next_cycles = cycles;
      if (slot) begin
         next_cycles = (state == ST_RUN) ? 2'h1 : cycles + 2'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= ST_RUN;
         stall_cnt <= 8'h00;
         skip_second <= 1'b0;
         cycles <= 2'h0;
         fetch_ready_out <= 1'b0;
         nop_slot_out <= 1'b0;
         exec_valid_out <= 1'b0;
         retire_out <= 1'b0;
         retire_cycles_out <= 2'h0;
      end else begin
         state <= next_state;
         stall_cnt <= next_stall_cnt;
         skip_second <= next_skip_second;
         cycles <= next_cycles;
         // fetch is held off while inserted slots drain
         fetch_ready_out <= (next_state != ST_STALL);
         nop_slot_out <= next_nop;
         exec_valid_out <= next_exec;
         retire_out <= next_retire;
         retire_cycles_out <= next_retire ? next_cycles : retire_cycles_out;
      end
   end

   // ---------------------------------------------------------------
   // decoded operands
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         decoded_out <= '0;
         x_prefetch_out <= '0;
         y_prefetch_out <= '0;
         operand_error_out <= 1'b0;
         second_word_error_out <= 1'b0;
      end else if (accept && state == ST_RUN) begin
         decoded_out <= word_dec;
         x_prefetch_out <= decode_prefetch(op[F_XPF_LSB +: 4], REG_W8, op[F_XD_LSB +: 2]);
         y_prefetch_out <= decode_prefetch(op[F_YPF_LSB +: 4], REG_W10, op[F_YD_LSB +: 2]);
         operand_error_out <= word_error;
         second_word_error_out <= 1'b0;
      end else if (accept && state == ST_SECOND) begin
         decoded_out.program_address_literal <=
            {fetch_word_in[PROGRAM_ADDRESS_LITERAL_HI_W-1:0], decoded_out.operand};
         // extension word must carry a zero opcode
         second_word_error_out <= (opc != SECOND_WORD_OPC);
         operand_error_out <= operand_error_out || decoded_out.operand[0];
      end
   end

   // ---------------------------------------------------------------
   // write gating and status flags
   // ---------------------------------------------------------------
   logic write_ok;

   // only real execute slots may write
   assign write_ok = next_exec && !next_nop;

   always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         reg_write_out <= 1'b0;
      end else begin
         reg_write_out <= reg_write_in && write_ok;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         mcu_flags_out <= '0;
         dsp_flags_out <= '0;
      end else if (flag_update_in && write_ok) begin
         // in sticky mode sticky zero can only be cleared, never set
         mcu_flags_out <= {mcu_flags_in[4:1], sticky_zero_mode_in ?
            (mcu_flags_out.sticky_zero_flag && mcu_flags_in.sticky_zero_flag) :
            mcu_flags_in.sticky_zero_flag};
         dsp_flags_out <= dsp_flags_in;
      end
   end

endmodule // instr_timing_decoder

/* design/decode_pkg.sv */
// constants, types and field layout of the instruction timing and operand decoder
package decode_pkg;
   localparam int INSTR_W = 24;
   localparam int OPC_W = 8;
   localparam int OPC_LSB = 16;
   localparam int OPERAND_W = 16;
   localparam logic [7:0] SECOND_WORD_OPC = 8'h00;
   localparam int PROGRAM_ADDRESS_LITERAL_W = 23;
   localparam int PROGRAM_ADDRESS_LITERAL_HI_W = 7;
   localparam logic [3:0] REG_W0 = 4'h0;
   localparam logic [3:0] REG_W4 = 4'h4;
   localparam logic [3:0] REG_W8 = 4'h8;
   localparam logic [3:0] REG_W10 = 4'hA;
   localparam logic [3:0] REG_W12 = 4'hC;
   localparam logic [3:0] REG_W13 = 4'hD;
   localparam logic [2:0] PF_STEP2 = 3'h2;
   localparam logic [2:0] PF_STEP4 = 3'h4;
   localparam logic [2:0] PF_STEP6 = 3'h6;
   localparam logic [2:0] MUL_PAIR_LAST = 3'h5;
   localparam logic [1:0] AWB_NONE = 2'h0;
   localparam logic [1:0] AWB_DIRECT = 2'h1;
   localparam logic [1:0] AWB_POSTINC = 2'h2;
   localparam logic [9:0] TEN_BIT_LITERAL_BYTE_MAX = 10'h0FF;
   localparam logic [12:0] FILE_ADDR_MAX = 13'h1FFF;
   // operand field positions inside the 16 operand bits; F_AWB_LSB counts from bit 0 of the whole word, into the opcode bits
   localparam int F_SRC_LSB = 0;
   localparam int F_DST_LSB = 7;
   localparam int F_BASE_LSB = 11;
   localparam int F_TEN_BIT_LITERAL_LSB = 4;
   localparam int F_BYTE_BIT = 14;
   localparam int F_DEFAULT_FILE_WORKING_REG_BIT = 13;
   localparam int F_BITPOS_LSB = 12;
   localparam int F_ACC_BIT = 15;
   localparam int F_PAIR_LSB = 12;
   localparam int F_XPF_LSB = 8;
   localparam int F_YPF_LSB = 4;
   localparam int F_XD_LSB = 2;
   localparam int F_YD_LSB = 0;
   localparam int F_AWB_LSB = 16;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SECOND = 2'b01,
      ST_STALL = 2'b11,
      ST_SKIP = 2'b10
   } state_t;

   typedef enum logic [2:0] {
      CLS_PLAIN = 3'h0,
      CLS_FILE = 3'h1,
      CLS_LIT = 3'h2,
      CLS_BIT = 3'h3,
      CLS_MUL = 3'h4,
      CLS_SQUARE = 3'h5
   } operand_class_t;

   typedef struct packed {
      logic carry_flag;
      logic digit_carry_flag;
      logic negative_flag;
      logic overflow_flag;
      logic sticky_zero_flag;
   } mcu_flags_t;

   typedef struct packed {
      logic first_sum_overflow_flag;
      logic second_sum_overflow_flag;
      logic first_sum_saturate_flag;
      logic second_sum_saturate_flag;
   } dsp_flags_t;

   typedef struct packed {
      logic enable;
      logic [3:0] pointer;
      logic indexed;
      logic decrement;
      logic [2:0] step;
      logic [3:0] dest;
   } prefetch_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [15:0] operand;
      logic [3:0] base_working_reg;
      logic [3:0] source_working_reg;
      logic [3:0] dest_working_reg;
      logic [3:0] default_file_working_reg;
      logic file_dest_is_default_file_working_reg;
      logic [12:0] file_addr;
      logic [3:0] bit_position_field;
      logic [9:0] ten_bit_literal;
      logic byte_mode;
      logic acc_b_select;
      logic [3:0] multiplicand_reg;
      logic [3:0] multiplier_reg;
      logic [1:0] accumulator_writeback_target;
      logic [22:0] program_address_literal;
   } decoded_t;
endpackage

/* testbench/instr_timing_decoder_sva.sv */
// port assertions for the instruction timing decoder
`timescale 1ns/10ps
module instr_timing_decoder_sva import decode_pkg::*; #(parameter int FLOW_EXTRA_CYCLES = 1) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic fetch_valid_in,
   input wire logic [INSTR_W-1:0] fetch_word_in,
   input wire logic fetch_two_word_in,
   input wire logic cond_true_in,
   input wire logic flow_change_in,
   input wire logic program_space_visibility_read_in,
   input wire logic table_read_in,
   input wire logic special_function_register_read_in,
   input wire logic skip_taken_in,
   input wire logic reg_write_in,
   input wire logic fetch_ready_out,
   input wire logic exec_valid_out,
   input wire logic nop_slot_out,
   input wire logic retire_out,
   input wire logic [1:0] retire_cycles_out,
   input wire logic reg_write_out,
   input wire mcu_flags_t mcu_flags_out,
   input wire dsp_flags_t dsp_flags_out
);
   // ----
   // word tracking
   // ----
   logic acc, plain, slow_hint, ext_pend, skip_pend, skip_ext;
   assign acc = fetch_valid_in && fetch_ready_out;
   assign plain = acc && !ext_pend && !skip_pend && !skip_ext;
   assign slow_hint = cond_true_in || flow_change_in || program_space_visibility_read_in
      || table_read_in || special_function_register_read_in;
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_pend <= 1'h0;
         skip_pend <= 1'h0;
         skip_ext <= 1'h0;
      end else if (acc) begin
         ext_pend <= plain && fetch_two_word_in;
         skip_pend <= plain && skip_taken_in && !fetch_two_word_in;
         skip_ext <= skip_pend && fetch_two_word_in;
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   a_single_one_cycle: assert property (
      plain && !fetch_two_word_in && !slow_hint && !skip_taken_in
      && fetch_word_in[23:16] != SECOND_WORD_OPC |=> exec_valid_out && retire_out
      && retire_cycles_out == 2'h1 && reg_write_out == $past(reg_write_in))
      else $error("single word not retired in one cycle");
   a_extra_nop_slot: assert property (
      plain && !fetch_two_word_in && slow_hint && !skip_taken_in
      |=> exec_valid_out && !fetch_ready_out ##1 nop_slot_out && retire_out
      && fetch_ready_out && retire_cycles_out == 2'(1 + FLOW_EXTRA_CYCLES))
      else $error("extra cycle not a nop slot");
   a_double_first_quiet: assert property (
      plain && fetch_two_word_in |=> !exec_valid_out && !retire_out && !nop_slot_out)
      else $error("first word of double executed alone");
   a_double_two_cycles: assert property (
      acc && ext_pend |=> exec_valid_out && retire_out && retire_cycles_out == 2'h2)
      else $error("double word not retired in two cycles");
   a_skip_single: assert property (
      acc && skip_pend && !fetch_two_word_in
      |=> nop_slot_out && retire_out && retire_cycles_out == 2'h2)
      else $error("skip over single word not two cycles");
   a_skip_double: assert property (
      acc && skip_ext |=> nop_slot_out && retire_out && retire_cycles_out == 2'h3)
      else $error("skip over double word not three cycles");
   a_lone_second_nop: assert property (
      plain && !fetch_two_word_in && fetch_word_in[23:16] == SECOND_WORD_OPC
      |=> nop_slot_out && !exec_valid_out && !reg_write_out)
      else $error("lone second word not a nop");
   a_nop_no_write: assert property (
      nop_slot_out |-> !reg_write_out && $stable(mcu_flags_out) && $stable(dsp_flags_out))
      else $error("nop slot wrote state");
   a_write_on_exec: assert property (
      reg_write_out |-> exec_valid_out)
      else $error("write outside an exec slot");
endmodule // instr_timing_decoder_sva

bind instr_timing_decoder instr_timing_decoder_sva #(.FLOW_EXTRA_CYCLES(FLOW_EXTRA_CYCLES))
   u_instr_timing_decoder_sva (.*);

/* testbench/prog_mem_model.sv */
// program memory model handing instruction words to the decoder
`timescale 1ns/10ps
module prog_mem_model import decode_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic fetch_ready_in,
   input wire logic slow_in,
   output logic fetch_valid_out,
   output logic [INSTR_W-1:0] fetch_word_out,
   output logic fetch_two_word_out,
   output logic [7:0] hint_out,
   output logic [2:0] class_out
);
   // entry: class, hints, two-word mark, word
   logic [35:0] prog[$];
   logic gap;
   initial begin
      {class_out, hint_out, fetch_two_word_out, fetch_word_out} = 36'h0;
      fetch_valid_out = 1'h0;
      gap = 1'h0;
   end
   task automatic push(input logic [35:0] e);
      prog.push_back(e);
   endtask
   // word held until taken; idle word toggles so stale data never looks valid
   always @(posedge clk_sys_in) begin
      if (fetch_valid_out && fetch_ready_in) begin
         void'(prog.pop_front());
      end
      #1;
      gap = slow_in && !gap;
      if (prog.size() != 0 && !gap) begin
         {class_out, hint_out, fetch_two_word_out, fetch_word_out} = prog[0];
         fetch_valid_out = 1'h1;
      end else begin
         fetch_valid_out = 1'h0;
         fetch_word_out = ~fetch_word_out;
      end
   end
endmodule // prog_mem_model

/* testbench/tb.sv */
// self-checking bench for the instruction timing decoder
`timescale 1ns/10ps
module tb import decode_pkg::*;;
   logic clk_sys_in, rst_b_in, slow, fetch_valid_in, fetch_two_word_in, sticky_zero_mode_in;
   logic cond_true_in, flow_change_in, program_space_visibility_read_in, table_read_in;
   logic special_function_register_read_in, skip_taken_in, reg_write_in, flag_update_in;
   logic [INSTR_W-1:0] fetch_word_in;
   logic [7:0] hint;
   logic [2:0] cls;
   operand_class_t operand_class_in;
   mcu_flags_t mcu_flags_in, mcu_flags_out;
   dsp_flags_t dsp_flags_in, dsp_flags_out;
   logic fetch_ready_out, exec_valid_out, nop_slot_out, retire_out, reg_write_out;
   logic operand_error_out, second_word_error_out;
   logic [1:0] retire_cycles_out;
   decoded_t decoded_out;
   prefetch_t x_prefetch_out, y_prefetch_out;
   int checks, n_mismatch;
   logic [7:0] pr[6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
   logic [9:0] lv[3] = '{10'h0FF, 10'h100, 10'h3FF};
   assign operand_class_in = operand_class_t'(cls);
   assign {flag_update_in, reg_write_in, skip_taken_in, special_function_register_read_in,
      table_read_in, program_space_visibility_read_in, flow_change_in, cond_true_in} = hint;

   instr_timing_decoder u_instr_timing_decoder (.clk_sys_in, .rst_b_in, .fetch_valid_in,
      .fetch_word_in, .fetch_two_word_in, .operand_class_in, .cond_true_in, .flow_change_in,
      .program_space_visibility_read_in, .table_read_in, .special_function_register_read_in,
      .skip_taken_in, .reg_write_in, .flag_update_in, .sticky_zero_mode_in, .mcu_flags_in,
      .dsp_flags_in, .fetch_ready_out, .exec_valid_out, .nop_slot_out, .retire_out,
      .retire_cycles_out, .decoded_out, .x_prefetch_out, .y_prefetch_out, .operand_error_out,
      .second_word_error_out, .reg_write_out, .mcu_flags_out, .dsp_flags_out);
   prog_mem_model u_prog_mem_model (.clk_sys_in, .fetch_ready_in(fetch_ready_out),
      .slow_in(slow), .fetch_valid_out(fetch_valid_in), .fetch_word_out(fetch_word_in),
      .fetch_two_word_out(fetch_two_word_in), .hint_out(hint), .class_out(cls));

   // ----
   // access and compare tasks
   // ----
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic put(input logic [23:0] w, input logic [2:0] c, input logic [7:0] h,
         input logic two);
      u_prog_mem_model.push({c, h, two, w});
   endtask
   // bounded wait for a retire or nop slot
   task automatic await(input logic nop_evt, input logic [1:0] cyc);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys_in);
         #1;
         if (nop_evt ? nop_slot_out === 1'h1 : retire_out === 1'h1) break;
      end
      if (i == 40) begin
         n_mismatch++;
         tally_and_finish();
      end else if (nop_evt !== 1'h1) begin
         cmp("retire cycles", 32'(cyc), 32'(retire_cycles_out));
      end
   endtask
   task automatic run(input logic [23:0] w, input logic [2:0] c, input logic [7:0] h,
         input logic [1:0] cyc);
      put(w, c, h, 1'h0);
      await(1'h0, cyc);
   endtask
   task automatic dbl(input logic [23:0] w, input logic [23:0] x, input logic e, input logic s);
      put(w, 3'h0, 8'h00, 1'h1);
      put(x, 3'h0, 8'h00, 1'h0);
      await(1'h0, 2'h2);
      cmp("address literal", 32'({x[6:0], w[15:0]}), 32'(decoded_out.program_address_literal));
      cmp("odd literal", 32'(e), 32'(operand_error_out));
      cmp("second word opcode", 32'(s), 32'(second_word_error_out));
   endtask
   task automatic chk_pf(input prefetch_t p, input logic [3:0] k, input logic [3:0] b,
         input logic [1:0] d);
      logic none, idx;
      none = k == 4'h4;
      idx = k == 4'hC;
      cmp("prefetch on", 32'(!none), 32'(p.enable));
      if (!none) begin
         cmp("prefetch reg", 32'(b + 4'(k[3])), 32'(p.pointer));
         cmp("prefetch indexed", 32'(idx), 32'(p.indexed));
         cmp("prefetch dest", 32'(REG_W4 + 4'(d)), 32'(p.dest));
      end
      if (!none && !idx) begin
         cmp("prefetch down", 32'(k[2]), 32'(p.decrement));
         cmp("prefetch step", 32'({k[1:0], 1'h0}), 32'(p.step));
      end
   endtask

   // ----
   // clock, reset and tests
   // ----
   initial begin
      clk_sys_in = 1'h0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      rst_b_in = 1'h0;
      slow = 1'h0;
      sticky_zero_mode_in = 1'h0;
      mcu_flags_in = 5'h00;
      dsp_flags_in = 4'h0;
      repeat (20) @(posedge clk_sys_in);
      #1 rst_b_in = 1'h1;
      repeat (3) @(posedge clk_sys_in);
      #1;
      run(24'h123456, 3'h0, 8'h40, 2'h1);
      cmp("opcode", 32'h12, 32'(decoded_out.opcode));
      cmp("operand", 32'h3456, 32'(decoded_out.operand));
      // each slow cause, with a write request that the nop slot must not repeat
      for (int k = 0; k < 5; k++) run(24'h400000, 3'h0, 8'h40 | (8'h01 << k), 2'h2);
      $display("test timing done");
      dbl(24'h021234, 24'h000056, 1'h0, 1'h0);
      dbl(24'h021235, 24'h00007F, 1'h1, 1'h0);
      dbl(24'h021234, 24'h010000, 1'h0, 1'h1);
      slow = 1'h1;
      dbl(24'h021234, 24'h000001, 1'h0, 1'h0);
      slow = 1'h0;
      $display("test double done");
      put(24'h300000, 3'h0, 8'h20, 1'h0);
      run(24'h400000, 3'h0, 8'h40, 2'h2);
      put(24'h300000, 3'h0, 8'h20, 1'h0);
      put(24'h020000, 3'h0, 8'h40, 1'h1);
      run(24'h000000, 3'h0, 8'h40, 2'h3);
      put(24'h00ABCD, 3'h0, 8'h40, 1'h0);
      await(1'h1, 2'h0);
      $display("test skip done");
      for (int k = 0; k < 8; k++) begin
         run({8'h60, 1'h0, 3'(k), 12'h000}, CLS_MUL, 8'h00, 2'h1);
         cmp("pair error", 32'(k > 5), 32'(operand_error_out));
         if (k < 6) cmp("multiplicand", 32'(pr[k][7:4]), 32'(decoded_out.multiplicand_reg));
         if (k < 6) cmp("multiplier", 32'(pr[k][3:0]), 32'(decoded_out.multiplier_reg));
      end
      for (int k = 0; k < 4; k++) begin
         run({8'h60, 2'h0, 2'(k), 12'h000}, CLS_SQUARE, 8'h00, 2'h1);
         cmp("square error", 32'h0, 32'(operand_error_out));
         cmp("square reg", 32'(4 + k), 32'(decoded_out.multiplier_reg));
         cmp("square pair", 32'(4 + k), 32'(decoded_out.multiplicand_reg));
      end
      for (int a = 0; a < 4; a++) begin
         run({6'h18, 2'(a), 16'h0000}, CLS_MUL, 8'h00, 2'h1);
         cmp("writeback error", 32'(a == 3), 32'(operand_error_out));
         if (a < 3) cmp("writeback", 32'(a), 32'(decoded_out.accumulator_writeback_target));
      end
      for (int k = 0; k < 16; k++) begin
         run({8'h60, 4'h0, 4'(k), 4'(15 - k), 2'(k), ~2'(k)}, CLS_MUL, 8'h00, 2'h1);
         chk_pf(x_prefetch_out, 4'(k), REG_W8, 2'(k));
         chk_pf(y_prefetch_out, 4'(15 - k), REG_W10, ~2'(k));
      end
      run(24'h603FFF, CLS_FILE, 8'h00, 2'h1);
      cmp("file address", 32'h1FFF, 32'(decoded_out.file_addr));
      cmp("file to default_file_working_reg", 32'h1, 32'(decoded_out.file_dest_is_default_file_working_reg));
      cmp("file default_file_working_reg", 32'(REG_W0), 32'(decoded_out.default_file_working_reg));
      for (int i = 0; i < 3; i++) begin
         run({8'h60, 1'h0, 1'(i < 2), lv[i], 4'h0}, CLS_LIT, 8'h00, 2'h1);
         cmp("literal", 32'(lv[i]), 32'(decoded_out.ten_bit_literal));
         cmp("literal error", 32'(i == 1), 32'(operand_error_out));
      end
      run(24'h60F000, CLS_BIT, 8'h00, 2'h1);
      cmp("bit position", 32'hF, 32'(decoded_out.bit_position_field));
      run(24'h608000, CLS_MUL, 8'h00, 2'h1);
      cmp("accumulator", 32'h1, 32'(decoded_out.acc_b_select));
      $display("test operands done");
      mcu_flags_in = 5'h1F;
      dsp_flags_in = 4'hA;
      run(24'h400000, 3'h0, 8'h80, 2'h1);
      cmp("core flags", 32'h1F, 32'(mcu_flags_out));
      cmp("dsp flags", 32'hA, 32'(dsp_flags_out));
      sticky_zero_mode_in = 1'h1;
      mcu_flags_in = 5'h0E;
      run(24'h400000, 3'h0, 8'h80, 2'h1);
      cmp("core flags", 32'h0E, 32'(mcu_flags_out));
      mcu_flags_in = 5'h01;
      run(24'h400000, 3'h0, 8'h80, 2'h1);
      cmp("sticky zero", 32'h00, 32'(mcu_flags_out));
      $display("test flags done");
      tally_and_finish();
   end
endmodule // tb
